// File: frm_fault_mgr.sv
// fault response manager of a load_regulator, with an APB register slave
// assumes a single 25 MHz clock, synchronous active-low reset, open-drain group lines
//
// Overview of operation
// RULE1 - an injected fault trigger stays present exactly while its inject bit is set.
// RULE2 - injected and real faults of a type share one trigger and one response path.
// RULE3 - a fault shuts the regulator down and drives group lines as its response asks.
// RULE4 - another group's line is driven only for a system response or when propagation to that group is enabled.
// RULE5 - a non-latching fault restarts the regulator 130 ms after its trigger clears.
// RULE6 - group members shut by the fault restart when the line is released at restart.
// RULE7 - clearing a latching trigger leaves the regulator off until an explicit clear.
// RULE8 - taking the enable pin low clears a latched fault; high again lets it start.
// RULE9 - an off command clears the latched fault and an on command re-enables output.
// RULE10 - the sync_data_line gives both the sync edge and the received data bits.
// RULE11 - each group output is wired to the shared line of the group assigned to it.
// RULE12 - active fault types and the latch are reported while present or latched.
`timescale 1ns/1ps
module frm_fault_mgr import frm_pkg::*; #(
  parameter int unsigned HICCUP_CYC_P = HICCUP_CYC
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [3:0] FAULT_I,
  input wire logic EN_I,
  input wire logic SYNC_DATA_I,
  input wire logic [3:0] GRP_FAULT_N_I,
  output logic [3:0] GRP_FAULT_O,
  output logic [3:0] GRP_FAULT_OE_O,
  output logic POWER_ON_O,
  output logic SYNC_PULSE_O,
  output logic IRQ_O
);
  // synchronised pins
  logic [9:0] pins_s;
  logic [3:0] flt_s;
  logic en_s;
  logic sdl_s;
  logic [3:0] grp_low_s;

  // registers
  logic [3:0] inj_q;
  logic [19:0] cfg_q;
  logic run_cmd_q;
  logic [3:0] int_sts_q;
  logic [3:0] int_mask_q;
  logic [31:0] prdata_q;
  logic [3:0] flt_type_q;
  logic latch_q;
  logic [3:0] oe_q;
  logic [OWN_HIST-1:0] own_hist_q;
  logic power_q;
  frm_state_t state_q, state_d;

  // sync_data_line receiver
  logic sdl_prev_q;
  logic [4:0] sdl_cnt_q;
  logic sdl_busy_q;
  logic [7:0] sdl_rx_q;
  logic sync_pulse_q;

  // combinational
  logic wr_en, rd_setup, off_req, on_req, enabled, trig_any, ext_flt, hic_done, faulted;
  logic [3:0] trig_w, latch_mask, prop_en, oe_d, own_mask, int_set;
  logic [7:0] resp_cfg;
  logic [1:0] own_grp, resp_w;

  // register index decode, -1 when unmapped
  function automatic int addr_idx(input logic [11:0] a);
    unique case (a)
      ADDR_INJECT: return 0;
      ADDR_CONFIG: return 1;
      ADDR_CMD: return 2;
      ADDR_STATUS: return 3;
      ADDR_INT_STS: return 4;
      ADDR_INT_MASK: return 5;
      default: return -1;
    endcase
  endfunction : addr_idx

  // worst response among the given fault types
  function automatic logic [1:0] resp_of(input logic [7:0] cfg, input logic [3:0] types);
    logic [1:0] r;
    r = RESP_SELF;
    for (int i = 0; i < 4; i++) begin
      if (types[i] && (cfg[2*i +: 2] > r)) begin
        r = cfg[2*i +: 2];
      end
    end
    return r;
  endfunction : resp_of

  frm_sync #(.W(10)) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .d_i({GRP_FAULT_N_I, SYNC_DATA_I, EN_I, FAULT_I}),
    .q_o(pins_s)
  );

  assign flt_s = pins_s[3:0];
  assign en_s = pins_s[4];
  assign sdl_s = pins_s[5];
  assign grp_low_s = ~pins_s[9:6];

  frm_hiccup_timer #(.CYC(HICCUP_CYC_P)) u_hiccup (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .run_i(state_q == ST_HICCUP),
    .done_o(hic_done)
  );

  // config fields
  assign latch_mask = cfg_q[CFG_LATCH_LSB +: 4];
  assign resp_cfg = cfg_q[CFG_RESP_LSB +: 8];
  assign own_grp = cfg_q[CFG_GRP_LSB +: 2];
  assign prop_en = cfg_q[CFG_PROP_LSB +: 4];
  assign own_mask = 4'h1 << own_grp;

  // APB strobes; the slave answers in the first access cycle while enabled
  assign PREADY_O = CE_I;
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && CE_I && (addr_idx(PADDR_I) >= 0);
  assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign PSLVERR_O = PSEL_I && PENABLE_I && (addr_idx(PADDR_I) < 0);
  assign PRDATA_O = prdata_q;
  assign off_req = wr_en && (PADDR_I == ADDR_CMD) && PWDATA_I[CMD_OFF_BIT];
  assign on_req = wr_en && (PADDR_I == ADDR_CMD) && PWDATA_I[CMD_ON_BIT] && !off_req;

  // real and injected triggers merge into one path
  assign trig_w = flt_s | inj_q; // [RULE1] [RULE2]
  assign trig_any = |trig_w;
  assign enabled = en_s && run_cmd_q;
  assign faulted = (state_q == ST_FAULT) || (state_q == ST_HICCUP) || (state_q == ST_LATCHED);
  assign resp_w = resp_of(resp_cfg, flt_type_q);
  // own line low while nobody here drove it recently: a fault elsewhere in the group
  assign ext_flt = grp_low_s[own_grp] && !oe_q[own_grp] && !(|own_hist_q);

  // writable registers
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      inj_q <= 4'h0;
      cfg_q <= CFG_RST;
      int_mask_q <= IRQ_RST;
    end else if (wr_en) begin
      if (PADDR_I == ADDR_INJECT) inj_q <= PWDATA_I[3:0]; // [RULE1]
      if (PADDR_I == ADDR_CONFIG) cfg_q <= PWDATA_I[19:0];
      if (PADDR_I == ADDR_INT_MASK) int_mask_q <= PWDATA_I[3:0];
    end
  end

  // run command: off clears, on re-enables
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      run_cmd_q <= RUN_CMD_RST;
    end else if (off_req) begin
      run_cmd_q <= 1'b0; // [RULE9]
    end else if (on_req) begin
      run_cmd_q <= 1'b1; // [RULE9]
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      prdata_q <= 32'h00000000;
    end else if (CE_I && rd_setup) begin
      prdata_q <= 32'h00000000;
      unique case (addr_idx(PADDR_I))
        0: prdata_q[3:0] <= inj_q;
        1: prdata_q[19:0] <= cfg_q;
        2: prdata_q[CMD_ON_BIT] <= run_cmd_q;
        3: begin
          prdata_q[3:0] <= flt_type_q; // [RULE12]
          prdata_q[STS_LATCH_BIT] <= latch_q; // [RULE12]
          prdata_q[STS_RUN_BIT] <= (state_q == ST_RUN);
          prdata_q[STS_EXT_BIT] <= (state_q == ST_EXTOFF);
          prdata_q[STS_RX_LSB +: 8] <= sdl_rx_q;
        end
        4: prdata_q[3:0] <= int_sts_q;
        5: prdata_q[3:0] <= int_mask_q;
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // regulator state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: if (enabled && !trig_any && !ext_flt) state_d = ST_RUN;
      ST_RUN: begin
        if (trig_any) state_d = ST_FAULT; // [RULE3]
        else if (!enabled) state_d = ST_OFF;
        else if (ext_flt) state_d = ST_EXTOFF; // [RULE6]
      end
      ST_FAULT: if (!trig_any) state_d = latch_q ? ST_LATCHED : ST_HICCUP; // [RULE5] [RULE7]
      ST_HICCUP: begin
        if (trig_any) state_d = ST_FAULT;
        else if (hic_done) state_d = enabled ? ST_RUN : ST_OFF; // [RULE5]
      end
      ST_LATCHED: if (!en_s || off_req) state_d = ST_OFF; // [RULE7] [RULE8] [RULE9]
      ST_EXTOFF: begin
        if (trig_any) state_d = ST_FAULT;
        else if (!enabled) state_d = ST_OFF;
        else if (!ext_flt) state_d = ST_RUN; // [RULE6]
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state_q <= ST_OFF;
      power_q <= 1'b0;
    end else if (CE_I) begin
      state_q <= state_d;
      power_q <= (state_d == ST_RUN); // [RULE3]
    end
  end
  assign POWER_ON_O = power_q;

  // latch flag and reported fault types
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      latch_q <= 1'b0;
      flt_type_q <= 4'h0;
    end else if (CE_I) begin
      if (off_req || (state_q == ST_LATCHED && !en_s)) begin
        latch_q <= 1'b0; // [RULE8] [RULE9]
      end else if (|(trig_w & latch_mask) && state_q != ST_OFF) begin
        latch_q <= 1'b1; // [RULE7]
      end
      if (state_d == ST_FAULT || state_d == ST_HICCUP || state_d == ST_LATCHED) begin
        flt_type_q <= flt_type_q | trig_w; // [RULE12]
      end else begin
        flt_type_q <= trig_w;
      end
    end
  end

  // group line drive: own group, enabled groups, or all for a system response
  always_comb begin
    oe_d = 4'h0;
    if (faulted) begin
      if (resp_w == RESP_SYSTEM) oe_d = 4'hF; // [RULE3]
      else if (resp_w == RESP_GROUP) oe_d = own_mask | prop_en; // [RULE4] [RULE11]
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      oe_q <= 4'h0;
      own_hist_q <= '0;
    end else if (CE_I) begin
      oe_q <= oe_d; // [RULE6]
      own_hist_q <= {own_hist_q[OWN_HIST-2:0], oe_q[own_grp]};
    end
  end
  assign GRP_FAULT_O = 4'h0;
  assign GRP_FAULT_OE_O = oe_q;

  // sync_data_line: falling edge is sync, level a fixed time later is data
  // previous level resets low: the flushed synchroniser reads low, so no false edge
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      sdl_prev_q <= 1'b0;
      sdl_cnt_q <= 5'h00;
      sdl_busy_q <= 1'b0;
      sdl_rx_q <= 8'h00;
      sync_pulse_q <= 1'b0;
    end else if (CE_I) begin
      sdl_prev_q <= sdl_s;
      sync_pulse_q <= sdl_prev_q && !sdl_s; // [RULE10]
      if (sdl_prev_q && !sdl_s) begin
        sdl_busy_q <= 1'b1;
        sdl_cnt_q <= 5'h00;
      end else if (sdl_busy_q) begin
        sdl_cnt_q <= sdl_cnt_q + 5'h01;
        if (sdl_cnt_q == 5'(SDL_SAMPLE_CYC - 1)) begin
          sdl_busy_q <= 1'b0;
          sdl_rx_q <= {sdl_rx_q[6:0], sdl_s}; // [RULE10]
        end
      end
    end
  end
  assign SYNC_PULSE_O = sync_pulse_q;

  // interrupt events; a new event wins over a write-one clear
  assign int_set[IRQ_FAULT] = (state_q != ST_FAULT) && (state_d == ST_FAULT);
  assign int_set[IRQ_RESTART] = (state_q == ST_HICCUP) && (state_d == ST_RUN);
  assign int_set[IRQ_LATCH] = (state_q != ST_LATCHED) && (state_d == ST_LATCHED);
  assign int_set[IRQ_EXT] = (state_q != ST_EXTOFF) && (state_d == ST_EXTOFF);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      int_sts_q <= IRQ_RST;
    end else if (CE_I) begin
      if (wr_en && PADDR_I == ADDR_INT_STS) begin
        int_sts_q <= (int_sts_q & ~PWDATA_I[3:0]) | int_set;
      end else begin
        int_sts_q <= int_sts_q | int_set;
      end
    end
  end
  assign IRQ_O = |(int_sts_q & int_mask_q);

  // checks
  a_inject_enters_fault: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE2]
    (CE_I && state_q == ST_RUN && |inj_q) |=> (state_q == ST_FAULT && !POWER_ON_O))
    else $error("injected fault did not shut the regulator down");
  a_inject_drop_clears: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE1]
    (CE_I && state_q == ST_FAULT && flt_s == 4'h0 && inj_q == 4'h0) |=> (state_q != ST_FAULT))
    else $error("withdrawn injection still holds the fault");
  a_hiccup_no_early: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE5]
    (state_q == ST_HICCUP && !hic_done) |=> (state_q != ST_RUN))
    else $error("restart before hiccup time");
  a_hiccup_restart: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE5]
    (CE_I && hic_done && !trig_any && enabled) |=> (state_q == ST_RUN) ##0 POWER_ON_O)
    else $error("no restart after hiccup time");
  a_latch_stays_off: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE7]
    (state_q == ST_LATCHED && en_s && !off_req) |=> (state_q == ST_LATCHED && !POWER_ON_O))
    else $error("latched fault left without a clear");
  a_enable_clears: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE8]
    (CE_I && state_q == ST_LATCHED && !en_s) |=> (state_q == ST_OFF && !latch_q))
    else $error("enable pin did not clear the latch");
  a_off_cmd_clears: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE9]
    off_req |=> (!latch_q && !run_cmd_q))
    else $error("off command did not clear the fault");
  a_prop_blocked: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE4]
    (CE_I && resp_w == RESP_GROUP) |=> ((oe_q & ~($past(own_mask) | $past(prop_en))) == 4'h0))
    else $error("group line driven without propagation enable");
  a_fault_reported: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE12]
    (CE_I && trig_w[OVER_TEMPERATURE_FAULT]) |=> flt_type_q[OVER_TEMPERATURE_FAULT])
    else $error("over_temperature_fault not reported");
  a_real_fault_off: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE3]
    (CE_I && state_q == ST_RUN && |flt_s) |=> (state_q == ST_FAULT && !POWER_ON_O))
    else $error("real fault did not shut the regulator down");
  a_sync_sample: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE10]
    (CE_I && sdl_prev_q && !sdl_s) |=> SYNC_PULSE_O)
    else $error("sync edge not reported");
  a_sync_data_bit: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // [RULE10]
    (CE_I && sdl_busy_q && sdl_cnt_q == 5'(SDL_SAMPLE_CYC - 1) && !(sdl_prev_q && !sdl_s))
      |=> (sdl_rx_q[0] == $past(sdl_s)))
    else $error("sync_data_line bit not captured");
  c_hiccup_restart: cover property (@(posedge CLK_SYS_I) state_q == ST_HICCUP ##1 state_q == ST_RUN);
  c_latch_cmd_clear: cover property (@(posedge CLK_SYS_I) (state_q == ST_LATCHED && off_req));
  c_group_shutdown: cover property (@(posedge CLK_SYS_I) state_q == ST_EXTOFF ##1 state_q == ST_RUN);
endmodule : frm_fault_mgr

// File: frm_hiccup_timer.sv
// hiccup timer: counts while run_i is high, done_o in its last cycle
// assumes run_i drops for at least one enabled cycle between waits
`timescale 1ns/1ps
module frm_hiccup_timer import frm_pkg::*; #(
  parameter int unsigned CYC = HICCUP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  output logic done_o
);
  localparam logic [HICCUP_W-1:0] LAST = HICCUP_W'(CYC - 1);
  logic [HICCUP_W-1:0] cnt_q;

  // count up from zero while waiting, restart when idle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (!run_i || done_o) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + HICCUP_W'(1);
      end
    end
  end

  assign done_o = run_i && (cnt_q == LAST);
endmodule : frm_hiccup_timer

// File: frm_mgr_model.sv
// far-side model: power manager sync/data line and wired group fault lines
// assumes pull-ups on every shared line; tb drives ext_pull_i for other members
`timescale 1ns/1ps
module frm_mgr_model (
  input wire logic clk_i,
  input wire logic [3:0] grp_oe_i,
  input wire logic [3:0] ext_pull_i,
  output logic sync_data_o,
  output logic [3:0] grp_line_n_o
);
  // open-drain wire per group, low when any member pulls
  assign grp_line_n_o = ~(grp_oe_i | ext_pull_i);

  // line idles high on its pull-up between frames
  initial begin
    sync_data_o = 1'b1;
  end

  // falling edge is the sync, data held around the sample point
  task automatic send_bit(input logic b);
    @(posedge clk_i);
    sync_data_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    sync_data_o <= b;
    repeat (16) @(posedge clk_i);
    sync_data_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : send_bit
endmodule : frm_mgr_model

// File: frm_pkg.sv
// constants, register map and state type of the fault response manager
// assumes a 25 MHz system clock and a 32-bit APB register bus
package frm_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned HICCUP_MS = 130;
  localparam int unsigned HICCUP_CYC = HICCUP_MS * (CLK_HZ / 1000);
  localparam int unsigned HICCUP_W = 22;
  localparam int unsigned SDL_SAMPLE_NS = 400;
  localparam int unsigned SDL_SAMPLE_CYC = (SDL_SAMPLE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned OWN_HIST = 3;

  // register byte addresses
  localparam logic [11:0] ADDR_INJECT = 12'h000;
  localparam logic [11:0] ADDR_CONFIG = 12'h004;
  localparam logic [11:0] ADDR_CMD = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_INT_STS = 12'h010;
  localparam logic [11:0] ADDR_INT_MASK = 12'h014;

  // config field positions
  localparam int unsigned CFG_LATCH_LSB = 0;
  localparam int unsigned CFG_RESP_LSB = 4;
  localparam int unsigned CFG_GRP_LSB = 12;
  localparam int unsigned CFG_PROP_LSB = 16;
  localparam logic [19:0] CFG_RST = 20'h00000;
  // command bits
  localparam int unsigned CMD_OFF_BIT = 0;
  localparam int unsigned CMD_ON_BIT = 1;
  localparam logic RUN_CMD_RST = 1'b1;
  // status field positions
  localparam int unsigned STS_LATCH_BIT = 4;
  localparam int unsigned STS_RUN_BIT = 5;
  localparam int unsigned STS_EXT_BIT = 6;
  localparam int unsigned STS_RX_LSB = 8;
  // interrupt bits
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_RESTART = 1;
  localparam int unsigned IRQ_LATCH = 2;
  localparam int unsigned IRQ_EXT = 3;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // fault response codes, one 2-bit field per fault type
  localparam logic [1:0] RESP_SELF = 2'h0;
  localparam logic [1:0] RESP_GROUP = 2'h1;
  localparam logic [1:0] RESP_SYSTEM = 2'h2;
  // fault type index 0 is the over_temperature_fault
  localparam int unsigned OVER_TEMPERATURE_FAULT = 0;

  typedef enum logic [2:0] {
    ST_OFF, ST_RUN, ST_FAULT, ST_HICCUP, ST_LATCHED, ST_EXTOFF
  } frm_state_t;

endpackage : frm_pkg

// File: frm_sync.sv
// two-stage synchroniser for pin inputs
// assumes asynchronous inputs and a clock enable shared with the block
`timescale 1ns/1ps
module frm_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : frm_sync

// File: tb_fault_response_manager.sv
// testbench of the fault response manager: APB, fault, recovery and sync scenarios
// assumes frm_mgr_model as the far side and CE_I held high
`timescale 1ns/1ps
module tb_fault_response_manager;
  import frm_pkg::*;
  localparam int unsigned HC = 20;
  logic clk, rst_n, psel, penable, pwrite, en, rerr, pslverr, pready, pwr_on, sync_p, irq, sdl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] fault, ext_pull, oe, gout, gline;
  int n_errors, num_checks, n_sync;
  logic q_bits[$];

  frm_fault_mgr #(.HICCUP_CYC_P(HC)) u_frm_fault_mgr (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .FAULT_I(fault), .EN_I(en),
    .SYNC_DATA_I(sdl), .GRP_FAULT_N_I(gline), .GRP_FAULT_O(gout), .GRP_FAULT_OE_O(oe),
    .POWER_ON_O(pwr_on), .SYNC_PULSE_O(sync_p), .IRQ_O(irq)
  );

  frm_mgr_model u_frm_mgr_model (
    .clk_i(clk), .grp_oe_i(oe), .ext_pull_i(ext_pull), .sync_data_o(sdl), .grp_line_n_o(gline)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // count sync pulses seen by the block
  always @(posedge clk) begin
    if (sync_p === 1'b1) n_sync <= n_sync + 1;
  end

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      wrap_up();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded wait for the power output to reach v
  task automatic wait_pwr(input logic v, input int lim, output int n);
    n = 0;
    while (pwr_on !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        $display("[FAIL] t=%0t got=%h exp=%h", $time, pwr_on, v);
        n_errors++;
        wrap_up();
      end
    end
  endtask : wait_pwr

  // trigger a non-latching fault, check response, removal and hiccup restart
  task automatic fault_case(input int t, input logic [1:0] r, input logic [3:0] pm,
                            input logic [1:0] g, input logic pin);
    int n;
    logic [3:0] eo;
    eo = (r == RESP_SYSTEM) ? 4'hF : (r == RESP_GROUP) ? (pm | (4'h1 << g)) : 4'h0;
    apb(1'b1, ADDR_CONFIG, (32'(pm) << CFG_PROP_LSB) | (32'(g) << CFG_GRP_LSB)
        | (32'(r) << (CFG_RESP_LSB + 2 * t)));
    if (pin) fault[t] <= 1'b1;
    else apb(1'b1, ADDR_INJECT, 32'h1 << t);
    wait_pwr(1'b0, 10, n);
    repeat (3) @(posedge clk);
    chk(32'(oe), 32'(eo));
    chk(32'(gout), 32'h0);
    chk(32'(irq), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[5:0], 6'h1 << t);
    apb(1'b0, ADDR_INJECT, 32'h0);
    chk(rdat, pin ? 32'h0 : 32'h1 << t);
    if (pin) fault[t] <= 1'b0;
    else apb(1'b1, ADDR_INJECT, 32'h0);
    wait_pwr(1'b1, HC + 30, n);
    chk(32'(n >= HC && n <= HC + 12), 32'h1);
    @(posedge clk);
    chk(32'(oe), 32'h0);
    apb(1'b0, ADDR_INT_STS, 32'h0);
    chk(rdat, 32'h3);
    apb(1'b1, ADDR_INT_STS, 32'hF);
    apb(1'b0, ADDR_INT_STS, 32'h0);
    chk({rdat[31:1], irq}, 32'h0);
  endtask : fault_case

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    int n;
    logic [7:0] b;
    logic [7:0] eb;
    logic [11:0] ra[6] = '{ADDR_INJECT, ADDR_CONFIG, ADDR_CMD, ADDR_INT_STS, ADDR_INT_MASK, 12'h018};
    logic [31:0] re[6] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fault = 4'h0;
    ext_pull = 4'h0;
    en = 1'b1;
    n_errors = 0;
    num_checks = 0;
    n_sync = 0;
    void'($urandom(46));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and unmapped access
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rdat, re[i]);
      chk(32'(rerr), (i == 5) ? 32'h1 : 32'h0);
    end
    wait_pwr(1'b1, 40, n);
    $display("done: reset values");
    apb(1'b1, ADDR_INT_MASK, 32'hF);
    for (int i = 0; i < 6; i++) begin
      fault_case($urandom % 4, 2'(i % 3), 4'($urandom), 2'($urandom), i[0]);
    end
    $display("done: non-latching faults");
    // latching fault, interrupt masked, cleared by enable pin
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    apb(1'b1, ADDR_CONFIG, 32'h1);
    apb(1'b1, ADDR_INJECT, 32'h1);
    wait_pwr(1'b0, 10, n);
    apb(1'b1, ADDR_INJECT, 32'h0);
    repeat (HC + 20) @(posedge clk);
    chk(32'(pwr_on), 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[4], 1'b1);
    apb(1'b0, ADDR_INT_STS, 32'h0);
    chk({rdat[2], irq}, 2'b10);
    en <= 1'b0;
    repeat (8) @(posedge clk);
    en <= 1'b1;
    wait_pwr(1'b1, 40, n);
    // latching fault cleared by off then on command
    apb(1'b1, ADDR_INJECT, 32'h1);
    wait_pwr(1'b0, 10, n);
    apb(1'b1, ADDR_INJECT, 32'h0);
    apb(1'b1, ADDR_CMD, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({rdat[4], pwr_on}, 2'b00);
    apb(1'b1, ADDR_CMD, 32'h2);
    wait_pwr(1'b1, 40, n);
    $display("done: latched faults");
    // another member of our group pulls the shared line
    apb(1'b1, ADDR_CONFIG, 32'h1000);
    ext_pull <= 4'b0010;
    wait_pwr(1'b0, 20, n);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[6], 1'b1);
    ext_pull <= 4'b0000;
    wait_pwr(1'b1, HC + 40, n);
    $display("done: group shutdown");
    // eight bits on the sync/data line, LSB first
    b = 8'($urandom);
    n = n_sync;
    for (int i = 0; i < 8; i++) begin
      q_bits.push_back(b[i]);
      u_frm_mgr_model.send_bit(b[i]);
    end
    eb = 8'h0;
    // each bit shifts in at the bottom, so the first one sent ends in the top bit
    for (int i = 0; i < 8; i++) eb = {eb[6:0], q_bits.pop_front()};
    chk(n_sync - n, 32'h8);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[15:8], eb);
    $display("done: sync data");
    // mid-run reset: registers return to reset values, no false sync bit afterwards
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'(pwr_on), 32'h0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rdat, 32'h0);
    wait_pwr(1'b1, 40, n);
    repeat (12) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[15:0], 16'h0020);
    $display("done: mid-run reset");
    wrap_up();
  end
endmodule : tb_fault_response_manager
